// ==== core/sps_top.sv ====
// byte-wide serial port, master or slave, with AXI4-Lite register access
`timescale 1ns/1ps
// Function
// - master serial clock is system clock divided by 2, 4, 16 or 32 per rate code
// - slave mode ignores rate code and shifts on the external serial clock
// - transfer-complete flag sets once all eight bits are shifted
// - complete flag clears only by flags read seeing it, then byte access
// - byte write during transfer sets collision flag, is dropped, transfer continues
// - mode-fault flag sets while select input is low in master mode
// - master transfer starts only on a byte register write
// - byte write loads shift register; eight bits out and eight in
// - flags register is read-only; flags set by events, cleared by sequences
// - phase and polarity bits choose which clock edge shifts and which samples
// - control register bits 7..0: ie, enable, unused, master, polarity, phase, rate
// - flags register: complete bit 7, collision bit 6, mode fault bit 4
// - with polarity 0 the serial clock stays low outside transfers
// - interrupt requested while enabled and complete or mode-fault flag set
// - bits shift most significant first in both modes
// - master transfer makes exactly eight serial clock cycles then stops
// - with system enable 0 all four pins are inputs only
module sps_top #(
  parameter int unsigned ADDR_W = sps_pkg::SPS_ADDR_W
) (
  input  wire logic              CLK_SYS_I,
  input  wire logic              RSTN_I,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  input  wire logic              SCK_I,
  output logic                   SCK_O,
  output logic                   SCK_OE_O,
  input  wire logic              MOSI_I,
  output logic                   MOSI_O,
  output logic                   MOSI_OE_O,
  input  wire logic              MISO_I,
  output logic                   MISO_O,
  output logic                   MISO_OE_O,
  input  wire logic              SS_N_I,
  output logic                   IRQ_O
);
  import sps_pkg::*;

  // ************************************************
  // register bus slave
  // ************************************************
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;
  sps_ctrl_t         ctrl;
  logic              transfer_complete_flag;
  logic              write_collision_flag;
  logic              mode_fault_flag;
  logic [7:0]        rbuf;

  function automatic sps_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
    if (addr == ADDR_W'(SPS_CTRL_ADDR)) begin
      return SPS_SEL_CTRL;
    end else if (addr == ADDR_W'(SPS_FLAGS_ADDR)) begin
      return SPS_SEL_FLAGS;
    end else if (addr == ADDR_W'(SPS_BYTE_ADDR)) begin
      return SPS_SEL_BYTE;
    end
    return SPS_SEL_NONE;
  endfunction

  wire       wr_fire  = !S_AXI_AWREADY_O && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
  wire       rd_fire  = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  sps_sel_t  wr_sel;
  sps_sel_t  rd_sel;
  assign wr_sel = reg_sel(aw_addr);
  assign rd_sel = reg_sel(S_AXI_ARADDR_I);
  wire       wr_ctrl   = wr_fire && (wr_sel == SPS_SEL_CTRL) && w_lane0;
  wire       wr_byte   = wr_fire && (wr_sel == SPS_SEL_BYTE) && w_lane0;
  wire       rd_flags  = rd_fire && (rd_sel == SPS_SEL_FLAGS);
  wire       byte_acc  = wr_byte || (rd_fire && (rd_sel == SPS_SEL_BYTE));
  wire [7:0] flags_val = {transfer_complete_flag, write_collision_flag, 1'b0,
                          mode_fault_flag, 4'h0};
  wire [7:0] rd_byte   = (rd_sel == SPS_SEL_CTRL)  ? ctrl :
                         (rd_sel == SPS_SEL_FLAGS) ? flags_val :
                         (rd_sel == SPS_SEL_BYTE)  ? rbuf : 8'h00;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O  <= 1'b1;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= SPS_RESP_OKAY;
      aw_addr         <= '0;
      w_byte          <= 8'h00;
      w_lane0         <= 1'b0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        S_AXI_AWREADY_O <= 1'b0;
        aw_addr         <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        S_AXI_WREADY_O <= 1'b0;
        w_byte         <= S_AXI_WDATA_I[7:0];
        w_lane0        <= S_AXI_WSTRB_I[0];
      end
      if (wr_fire) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= (wr_sel == SPS_SEL_NONE) ? SPS_RESP_SLVERR : SPS_RESP_OKAY;
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O  <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= SPS_RESP_OKAY;
    end else if (rd_fire) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b1;
      S_AXI_RDATA_O   <= {24'h00_0000, rd_byte};
      S_AXI_RRESP_O   <= (rd_sel == SPS_SEL_NONE) ? SPS_RESP_SLVERR : SPS_RESP_OKAY;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl <= SPS_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= w_byte;
    end
  end

  // ************************************************
  // transfer sequencing
  // ************************************************
  sps_state_t state;
  logic [7:0] sr;
  logic       out_bit;
  logic       rx_bit;
  logic [2:0] bit_cnt;
  logic [3:0] half_cnt;
  logic       sck_prev;
  logic       div_tick;

  wire master   = ctrl.port_system_enable && ctrl.master_select;
  wire slave    = ctrl.port_system_enable && !ctrl.master_select;
  wire busy     = (state == SPS_RUN);
  wire m_run    = busy && master;
  wire s_sel    = slave && !SS_N_I;
  wire s_change = s_sel && (SCK_I != sck_prev);
  // leading edge leaves the idle level, trailing edge returns to it
  wire lead_ev  = m_run ? (div_tick && !half_cnt[0]) :
                          (s_change && (SCK_I != ctrl.clock_polarity));
  wire trail_ev = m_run ? (div_tick && half_cnt[0]) :
                          (s_change && (SCK_I == ctrl.clock_polarity));
  wire in_bit   = master ? MISO_I : MOSI_I;
  wire done_ev  = busy && trail_ev && (bit_cnt == 3'(SPS_BITS - 1));
  wire start_m  = wr_byte && !busy && master;
  wire s_abort  = busy && !ctrl.master_select && !s_sel;
  wire [7:0] next_sr = {sr[6:0], ctrl.clock_phase ? in_bit : rx_bit};

  sps_clkdiv u_clkdiv (
    .clk_i  (CLK_SYS_I),
    .rstn_i (RSTN_I),
    .run_i  (m_run),
    .rate_i (ctrl.rate),
    .tick_o (div_tick)
  );

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state <= SPS_IDLE;
    end else begin
      case (state)
        SPS_IDLE: begin
          if (start_m || (s_sel && lead_ev)) begin
            state <= SPS_RUN;
          end
        end
        SPS_RUN: begin
          if (done_ev || s_abort || !ctrl.port_system_enable) begin
            state <= SPS_IDLE;
          end
        end
        default: state <= SPS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sck_prev <= 1'b0;
      half_cnt <= 4'h0;
      bit_cnt  <= 3'h0;
    end else begin
      sck_prev <= SCK_I;
      if (!busy) begin
        half_cnt <= 4'h0;
        bit_cnt  <= 3'h0;
      end else begin
        half_cnt <= half_cnt + 4'(div_tick && m_run);
        bit_cnt  <= bit_cnt + 3'(trail_ev);
      end
    end
  end

  // shift register: byte write loads it, edges shift it
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sr      <= SPS_BYTE_RESET;
      out_bit <= 1'b0;
      rx_bit  <= 1'b0;
      rbuf    <= SPS_BYTE_RESET;
    end else if (wr_byte && !busy) begin
      sr      <= w_byte;
      out_bit <= w_byte[7];
    end else if (busy || (s_sel && lead_ev)) begin
      if (lead_ev) begin
        if (ctrl.clock_phase) begin
          out_bit <= sr[7];
        end else begin
          rx_bit <= in_bit;
        end
      end
      if (trail_ev) begin
        sr <= next_sr;
        if (!ctrl.clock_phase) begin
          out_bit <= sr[6];
        end
      end
      if (done_ev) begin
        rbuf <= next_sr;
      end
    end
  end

  // ************************************************
  // flags; a set in the same cycle beats the clear
  // ************************************************
  logic arm_done;
  logic arm_write_collision_flag;
  logic arm_mode_fault_flag;
  wire  mode_fault_flag_ev = ctrl.master_select && !SS_N_I;
  wire  write_collision_flag_ev = wr_byte && busy;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      transfer_complete_flag <= 1'b0;
      write_collision_flag   <= 1'b0;
      mode_fault_flag        <= 1'b0;
      arm_done               <= 1'b0;
      arm_write_collision_flag               <= 1'b0;
      arm_mode_fault_flag               <= 1'b0;
    end else begin
      if (rd_flags) begin
        arm_done <= transfer_complete_flag;
        arm_write_collision_flag <= write_collision_flag;
        arm_mode_fault_flag <= mode_fault_flag;
      end else begin
        if (byte_acc) begin
          arm_done <= 1'b0;
          arm_write_collision_flag <= 1'b0;
        end
        if (wr_ctrl) begin
          arm_mode_fault_flag <= 1'b0;
        end
      end
      if (done_ev) begin
        transfer_complete_flag <= 1'b1;
      end else if (byte_acc && arm_done) begin
        transfer_complete_flag <= 1'b0;
      end
      if (write_collision_flag_ev) begin
        write_collision_flag <= 1'b1;
      end else if (byte_acc && arm_write_collision_flag) begin
        write_collision_flag <= 1'b0;
      end
      if (mode_fault_flag_ev) begin
        mode_fault_flag <= 1'b1;
      end else if (wr_ctrl && arm_mode_fault_flag) begin
        mode_fault_flag <= 1'b0;
      end
    end
  end

  // ************************************************
  // pins and interrupt request
  // ************************************************
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SCK_O     <= 1'b0;
      SCK_OE_O  <= 1'b0;
      MOSI_OE_O <= 1'b0;
      MISO_OE_O <= 1'b0;
      IRQ_O     <= 1'b0;
    end else begin
      SCK_O     <= m_run ? (SCK_O ^ div_tick) : ctrl.clock_polarity;
      SCK_OE_O  <= master;
      MOSI_OE_O <= master;
      MISO_OE_O <= s_sel;
      IRQ_O     <= ctrl.port_interrupt_enable &&
                   (transfer_complete_flag || mode_fault_flag);
    end
  end

  assign MOSI_O = out_bit;
  assign MISO_O = out_bit;

  // ************************************************
  // assertions
  // ************************************************
  logic [4:0] sck_edges;
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sck_edges <= 5'h00;
    end else if (start_m) begin
      sck_edges <= 5'h00;
    end else if (SCK_O != $past(SCK_O)) begin
      sck_edges <= sck_edges + 5'h01;
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  property p_idle_sck;
    !m_run ##1 !m_run |-> SCK_O == $past(ctrl.clock_polarity);
  endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("serial clock not at idle level");

  property p_start_write;
    $rose(m_run) |-> $past(wr_byte);
  endproperty
  a_start_write: assert property (p_start_write) else $error("transfer began without write");

  property p_done_flag;
    done_ev |=> transfer_complete_flag && (rbuf == $past(next_sr));
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("completion not recorded");

  property p_done_hold;
    transfer_complete_flag && !(byte_acc && arm_done) |=> transfer_complete_flag;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("complete flag lost");

  property p_write_collision_flag;
    write_collision_flag_ev |=> write_collision_flag && busy && (sr == $past(sr) || $past(trail_ev));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision mishandled");

  property p_mode_fault_flag;
    mode_fault_flag_ev |=> mode_fault_flag;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault missed");

  property p_eight_clocks;
    $fell(m_run) && ctrl.master_select |=> sck_edges == 5'h10;
  endproperty
  a_eight_clocks: assert property (p_eight_clocks) else $error("wrong serial clock count");

  property p_pins_off;
    !ctrl.port_system_enable |=> !SCK_OE_O && !MOSI_OE_O && !MISO_OE_O;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pin driven while disabled");

  property p_rate16;
    $rose(m_run) && ctrl.rate == 2'b10 |-> !div_tick [*7] ##1 div_tick;
  endproperty
  a_rate16: assert property (p_rate16) else $error("divide by 16 wrong");

  property p_slave_rate;
    !ctrl.master_select |-> !div_tick;
  endproperty
  a_slave_rate: assert property (p_slave_rate) else $error("divider ran in slave mode");

  property p_msb_first;
    start_m && !ctrl.clock_phase |=> MOSI_O == $past(w_byte[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not msb");

  property p_irq;
    ctrl.port_interrupt_enable && mode_fault_flag |=> IRQ_O;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not requested");

  property p_slave_desel;
    slave && SS_N_I |=> state == SPS_IDLE;
  endproperty
  a_slave_desel: assert property (p_slave_desel) else $error("slave ran while deselected");

  c_master_done: cover property (done_ev && master);
  c_slave_done:  cover property (done_ev && slave);
  c_collision:   cover property (write_collision_flag_ev);
  c_mode_fault:  cover property ($rose(mode_fault_flag));

endmodule

// ==== inc/sps_pkg.sv ====
// constants, field layouts and types of the serial port block
package sps_pkg;

  // ************************************************
  // register indices and byte addresses
  // ************************************************
  localparam int unsigned SPS_CTRL_IDX  = 'h0a;
  localparam int unsigned SPS_FLAGS_IDX = 'h0b;
  localparam int unsigned SPS_BYTE_IDX  = 'h0c;
  localparam int unsigned SPS_ADDR_W    = 8;
  localparam logic [7:0]  SPS_CTRL_ADDR  = 8'(4 * SPS_CTRL_IDX);
  localparam logic [7:0]  SPS_FLAGS_ADDR = 8'(4 * SPS_FLAGS_IDX);
  localparam logic [7:0]  SPS_BYTE_ADDR  = 8'(4 * SPS_BYTE_IDX);

  // ************************************************
  // field positions and reset values
  // ************************************************
  localparam int unsigned SPS_FLAG_DONE_BIT = 7;
  localparam int unsigned SPS_FLAG_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int unsigned SPS_FLAG_MODE_FAULT_FLAG_BIT = 4;
  localparam logic [7:0]  SPS_CTRL_RESET    = 8'h00;
  localparam logic [7:0]  SPS_BYTE_RESET    = 8'h00;

  // ************************************************
  // serial clock divisors per rate code
  // ************************************************
  localparam int unsigned SPS_DIV_R00 = 2;
  localparam int unsigned SPS_DIV_R01 = 4;
  localparam int unsigned SPS_DIV_R10 = 16;
  localparam int unsigned SPS_DIV_R11 = 32;
  localparam int unsigned SPS_BITS    = 8;

  // ************************************************
  // bus answers and types
  // ************************************************
  localparam logic [1:0] SPS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SPS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SPS_SEL_CTRL, SPS_SEL_FLAGS, SPS_SEL_BYTE, SPS_SEL_NONE} sps_sel_t;

  typedef enum {SPS_IDLE, SPS_RUN} sps_state_t;

  typedef struct packed {
    logic       port_interrupt_enable;
    logic       port_system_enable;
    logic       unused;
    logic       master_select;
    logic       clock_polarity;
    logic       clock_phase;
    logic [1:0] rate;
  } sps_ctrl_t;

endpackage

// ==== core/sps_clkdiv.sv ====
// serial clock half-period tick generator for master mode
`timescale 1ns/1ps
module sps_clkdiv (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       run_i,
  input  wire logic [1:0] rate_i,
  output logic            tick_o
);
  import sps_pkg::*;

  logic [4:0] cnt;
  wire  [4:0] half_last;
  wire        at_last;

  // half period in system clocks, minus one
  function automatic logic [4:0] half_minus_one(input logic [1:0] rate);
    int unsigned div;
    case (rate)
      2'b00:   div = SPS_DIV_R00;
      2'b01:   div = SPS_DIV_R01;
      2'b10:   div = SPS_DIV_R10;
      default: div = SPS_DIV_R11;
    endcase
    return 5'(div / 2 - 1);
  endfunction

  assign half_last = half_minus_one(rate_i);
  assign at_last   = run_i && (cnt == half_last);
  assign tick_o    = at_last;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 5'h00;
    end else if (!run_i || at_last) begin
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end

endmodule

// ==== test/sps_peer.sv ====
// behavioural serial peripheral answering master transfers
`timescale 1ns/1ps
module sps_peer (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_n_i,
  input  wire logic       clock_polarity_i,
  input  wire logic       clock_phase_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic [7:0]      rx_o
);
  logic [7:0] sr;
  logic       drv;
  // a released line shows the inverse of the last bit, never a held value
  assign miso_o = sel_n_i ? ~drv : drv;
  initial begin
    sr   = 8'h00;
    drv  = 1'b0;
    rx_o = 8'h00;
  end
  always @(negedge sel_n_i) begin
    drv = tx_i[7];
    sr  = clock_phase_i ? tx_i : {tx_i[6:0], 1'b0};
  end
  always @(sck_i) begin
    if (!sel_n_i) begin
      if ((sck_i != clock_polarity_i) == !clock_phase_i) begin
        rx_o = {rx_o[6:0], mosi_i};
      end else begin
        drv = sr[7];
        sr  = {sr[6:0], 1'b0};
      end
    end
  end
endmodule

// ==== test/sps_top_bench.sv ====
// self-checking bench of the serial port: register access and serial traffic
`timescale 1ns/1ps
module sps_top_bench;
  import sps_pkg::*;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, peer_tx, peer_rx, rd8, fl;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, rsp;
  logic        awready, wready, bvalid, arready, rvalid, irq, sck_in, mosi_in, ss_n;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, peer_miso;
  logic        peer_sel_n, peer_clock_polarity, peer_clock_phase, sck_q;
  wire         sck_w  = sck_oe ? sck_o : sck_in;
  wire         mosi_w = mosi_oe ? mosi_o : mosi_in;
  wire         miso_w = miso_oe ? miso_o : peer_miso;
  int          error_cnt, checks, cyc, rise_cnt, last_rise, prev_rise;
  int          divs [4] = '{SPS_DIV_R00, SPS_DIV_R01, SPS_DIV_R10, SPS_DIV_R11};

  sps_top i_sps_top (.CLK_SYS_I(clk), .RSTN_I(rstn), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_O(sck_oe),
    .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE_O(mosi_oe), .MISO_I(miso_w),
    .MISO_O(miso_o), .MISO_OE_O(miso_oe), .SS_N_I(ss_n), .IRQ_O(irq));
  sps_peer i_sps_peer (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(peer_sel_n),
    .clock_polarity_i(peer_clock_polarity), .clock_phase_i(peer_clock_phase), .tx_i(peer_tx), .miso_o(peer_miso),
    .rx_o(peer_rx));

  always #10 clk = ~clk;
  // serial clock edge monitor
  always @(posedge clk) begin
    cyc   <= cyc + 1;
    sck_q <= sck_o;
    if (sck_o && !sck_q) begin
      rise_cnt  <= rise_cnt + 1;
      prev_rise <= last_rise;
      last_rise <= cyc;
    end
  end

  // ************************************************
  // tasks
  // ************************************************
  task automatic conclude;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic timeout;
    $display("[FAIL] t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1);
    error_cnt++;
    conclude();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    bit aw_hs, w_hs, b_hs;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      aw_hs = awvalid & awready;
      w_hs  = wvalid & wready;
      b_hs  = bready & bvalid;
      r     = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
      n++;
    end while (!b_hs && n < 200);
    if (!b_hs) timeout();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    bit ar_hs, r_hs;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      ar_hs = arvalid & arready;
      r_hs  = rready & rvalid;
      d     = rdata[7:0];
      r     = rresp;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
      n++;
    end while (!r_hs && n < 200);
    if (!r_hs) timeout();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk({r, d}, {SPS_RESP_OKAY, exp});
  endtask
  // select peer, send a byte (a second write if coll), poll completion, deselect
  task automatic xfer(input logic [7:0] d, input bit coll, output logic [7:0] f);
    int n;
    logic [1:0] r;
    @(posedge clk);
    peer_sel_n <= 1'b0;
    @(negedge clk);
    rise_cnt = 0;
    axi_wr(SPS_BYTE_ADDR, d, r);
    if (coll) axi_wr(SPS_BYTE_ADDR, ~d, r);
    f = 8'h00;
    n = 0;
    while (!f[7] && n < 400) begin
      axi_rd(SPS_FLAGS_ADDR, f, r);
      n++;
    end
    if (!f[7]) timeout();
    @(posedge clk);
    peer_sel_n <= 1'b1;
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    {clk, rstn, awvalid, wvalid, bready, arvalid, rready, sck_in, mosi_in} = '0;
    {awaddr, araddr, wdata, peer_clock_polarity, peer_clock_phase, peer_tx, cyc, rise_cnt} = '0;
    {error_cnt, checks, last_rise, prev_rise, sck_q} = '0;
    ss_n       = 1'b1;
    peer_sel_n = 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(SPS_CTRL_ADDR, SPS_CTRL_RESET);
    rd_chk(SPS_FLAGS_ADDR, 8'h00);
    axi_rd(8'h34, rd8, rsp);
    chk({rsp, rd8}, {SPS_RESP_SLVERR, 8'h00});
    axi_wr(SPS_FLAGS_ADDR, 8'hff, rsp);
    chk(32'(rsp), 32'(SPS_RESP_OKAY));
    axi_wr(8'h34, 8'h00, rsp);
    chk(32'(rsp), 32'(SPS_RESP_SLVERR));
    rd_chk(SPS_FLAGS_ADDR, 8'h00);
    $display("test registers done");
    axi_wr(SPS_CTRL_ADDR, 8'h50, rsp);
    rd_chk(SPS_CTRL_ADDR, 8'h50);
    chk({sck_oe, mosi_oe, 30'(rise_cnt)}, {2'b11, 30'h0});
    for (int r = 0; r < 4; r++) begin
      axi_wr(SPS_CTRL_ADDR, 8'h50 | 8'(r), rsp);
      xfer(8'h5a, 1'b0, fl);
      chk(32'(last_rise - prev_rise), 32'(divs[r]));
      chk({sck_o, 31'(rise_cnt)}, {1'b0, 31'h8});
    end
    $display("test rates done");
    axi_wr(SPS_CTRL_ADDR, 8'h51, rsp);
    axi_rd(SPS_BYTE_ADDR, rd8, rsp);
    peer_tx = 8'h3c;
    xfer(8'ha5, 1'b0, fl);
    chk({fl, peer_rx}, {8'h80, 8'ha5});
    axi_wr(SPS_CTRL_ADDR, 8'h51, rsp);
    rd_chk(SPS_FLAGS_ADDR, 8'h80);
    rd_chk(SPS_BYTE_ADDR, 8'h3c);
    rd_chk(SPS_FLAGS_ADDR, 8'h00);
    xfer(8'h81, 1'b1, fl);
    chk({fl, peer_rx}, {8'hc0, 8'h81});
    rd_chk(SPS_BYTE_ADDR, 8'h3c);
    rd_chk(SPS_FLAGS_ADDR, 8'h00);
    $display("test data done");
    axi_wr(SPS_CTRL_ADDR, 8'h5d, rsp);
    {peer_clock_polarity, peer_clock_phase, peer_tx} = {2'b11, 8'h96};
    xfer(8'hc3, 1'b0, fl);
    chk({sck_o, peer_rx}, {1'b1, 8'hc3});
    rd_chk(SPS_BYTE_ADDR, 8'h96);
    {peer_clock_polarity, peer_clock_phase} = 2'b00;
    axi_wr(SPS_CTRL_ADDR, 8'hd1, rsp);
    @(posedge clk) ss_n <= 1'b0;
    repeat (3) @(posedge clk);
    ss_n <= 1'b1;
    rd_chk(SPS_FLAGS_ADDR, 8'h10);
    chk(irq, 1'b1);
    axi_wr(SPS_CTRL_ADDR, 8'hd1, rsp);
    rd_chk(SPS_FLAGS_ADDR, 8'h00);
    chk(irq, 1'b0);
    xfer(8'h11, 1'b0, fl);
    chk(irq, 1'b1);
    $display("test phase and faults done");
    axi_wr(SPS_CTRL_ADDR, 8'h43, rsp);
    axi_wr(SPS_BYTE_ADDR, 8'hb4, rsp);
    @(posedge clk) ss_n <= 1'b0;
    rd8 = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= 1'(8'h69 >> i);
      repeat (2) @(posedge clk);
      rd8 = {rd8[6:0], miso_o};
      sck_in <= 1'b1;
      repeat (2) @(posedge clk);
      sck_in <= 1'b0;
    end
    repeat (3) @(posedge clk);
    chk({miso_oe, rd8}, {1'b1, 8'hb4});
    rd_chk(SPS_FLAGS_ADDR, 8'h80);
    rd_chk(SPS_BYTE_ADDR, 8'h69);
    axi_wr(SPS_CTRL_ADDR, 8'h00, rsp);
    repeat (2) @(posedge clk);
    chk({sck_oe, mosi_oe, miso_oe}, 3'b000);
    $display("test slave and disable done");
    conclude();
  end
endmodule
